// File: hdl/kms_pkg.sv
// Summary of operation
// RULE_01: Keys sit on any crossing of an 8 drive by 3 receive grid.
// RULE_02: Enabled key total never exceeds the variant limit, 16 or 24.
// RULE_03: Disabled keys are skipped and take no acquisition timeslot.
// RULE_04: A key with a zero detect-integrator limit counts as disabled.
// RULE_05: Small variant enables only receive lines 0 and 1 after reset.
// RULE_06: Scan starts at drive 0 receive 0, drive index stepping fastest.
// RULE_07: Key number equals receive index times eight plus drive index.
// RULE_08: Each key's burst uses its own configured pulse count; a count of zero gives one pulse.
// RULE_09: One key's burst and conversion finish before the next key starts.
// RULE_10: Drive pulses; receive is clamped from each falling edge to next pulse.
// RULE_11: After the burst, clamp, then count until the ramp crosses zero.
// RULE_12: Charge-capture window after each rising drive edge is fixed 500 ns.
// RULE_13: Host keeps each touch threshold below the smallest touch swing.
// RULE_14: Conversion count saturates at full scale, then the next key follows.
package kms_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int DWELL_NS = 500;
  localparam int DWELL_CYC = (DWELL_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_CYC_DEF = 100;
  localparam int CLAMP_CYC_DEF = 20;

  // ----------------------------------------------------------------
  // Geometry and register map
  // ----------------------------------------------------------------
  localparam int N_DRV = 8;
  localparam int N_RCV = 3;
  localparam int N_KEYS = 24;
  localparam logic [4:0] LAST_KEY = 5'h17;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h01;
  localparam logic [7:0] A_CFG = 8'h20;
  localparam logic [7:0] A_MEAS = 8'h40;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_COMMIT = 1;
  localparam int CTRL_ERR = 2;
  localparam logic [7:0] RST_LIMIT = 8'h02;
  localparam logic [7:0] RST_PULSES = 8'h08;
  localparam logic [15:0] CONV_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SELECT = 7'h02,
    ST_HI = 7'h04,
    ST_LO = 7'h08,
    ST_CLAMP = 7'h10,
    ST_RAMP = 7'h20,
    ST_NEXT = 7'h40
  } kms_state_t;

  typedef logic [N_KEYS-1:0][7:0] kms_byte_arr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } kms_bus_t;

  typedef struct packed {
    logic [N_DRV-1:0] drive;
    logic [N_RCV-1:0] clamp;
  } kms_pins_t;

  typedef struct packed {
    kms_state_t st;
    logic [4:0] key;
    logic [7:0] pulses;
    logic [7:0] tmr;
    logic [15:0] conv;
    logic [N_DRV-1:0] drive;
    logic [N_RCV-1:0] clamp;
    logic [N_RCV-1:0] zc_s1;
    logic [N_RCV-1:0] zc_s2;
    logic run;
    logic err;
    logic [15:0] scans;
    logic [31:0] rdata;
    kms_byte_arr_t lim;
    kms_byte_arr_t cnt;
    kms_byte_arr_t lim_sh;
    kms_byte_arr_t cnt_sh;
    logic [N_KEYS-1:0][15:0] meas;
  } kms_regs_t;

endpackage : kms_pkg

// File: hdl/kms_scan.sv
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module kms_scan #(
  parameter int KEY_LIMIT = 16,
  parameter int LOW_CYC = kms_pkg::LOW_CYC_DEF,
  parameter int CLAMP_CYC = kms_pkg::CLAMP_CYC_DEF
) (
  input wire logic clock,
  input wire logic srst,
  input wire kms_pkg::kms_bus_t bus,
  output logic [31:0] bus_rdata,
  output kms_pkg::kms_pins_t pins,
  input wire logic [kms_pkg::N_RCV-1:0] zero_cross
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Number of keys with a nonzero integrator limit
  function automatic logic [4:0] count_on(input kms_pkg::kms_byte_arr_t l);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < kms_pkg::N_KEYS; i++) begin
      if (l[i] != 8'h00) begin
        n = n + 5'h01;
      end
    end
    return n;
  endfunction : count_on

  // Zero limit means the key takes no part in the scan
  function automatic logic key_on(input kms_pkg::kms_byte_arr_t l, input logic [4:0] k);
    return (k <= kms_pkg::LAST_KEY) && (l[k] != 8'h00); // RULE_04
  endfunction : key_on

  // Address falls inside a 24-entry per-key window
  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
    return (a[7:5] == base[7:5]) && (a[4:0] <= kms_pkg::LAST_KEY);
  endfunction : in_win

  // One-hot line select for the key's drive or receive index
  function automatic logic [kms_pkg::N_DRV-1:0] drv_sel(input logic [4:0] k);
    return 8'h01 << k[2:0]; // RULE_07
  endfunction : drv_sel

  function automatic logic [kms_pkg::N_RCV-1:0] rcv_sel(input logic [4:0] k);
    return 3'h1 << k[4:3]; // RULE_07
  endfunction : rcv_sel

  // Reset image; keys below the variant limit come up enabled
  function automatic kms_pkg::kms_regs_t rst_val();
    kms_pkg::kms_regs_t v;
    v = '0;
    v.st = kms_pkg::ST_IDLE;
    for (int i = 0; i < kms_pkg::N_KEYS; i++) begin
      v.lim[i] = (i < KEY_LIMIT) ? kms_pkg::RST_LIMIT : 8'h00; // RULE_05
      v.cnt[i] = kms_pkg::RST_PULSES;
    end
    v.lim_sh = v.lim;
    v.cnt_sh = v.cnt;
    return v;
  endfunction : rst_val

  localparam logic [7:0] DWELL_LD = 8'(kms_pkg::DWELL_CYC - 1);
  localparam logic [7:0] LOW_LD = 8'(LOW_CYC - 1);
  localparam logic [7:0] CLAMP_LD = 8'(CLAMP_CYC - 1);
  localparam logic [4:0] LIMIT5 = 5'(KEY_LIMIT);

  kms_pkg::kms_regs_t r_ff;
  kms_pkg::kms_regs_t nxt_r;
  logic zc_now;

  // Only the second synchroniser stage feeds the comparator select
  assign zc_now = |(r_ff.zc_s2 & rcv_sel(r_ff.key));

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Register port, then the scan sequencer
  always_comb begin
    nxt_r = r_ff;
    nxt_r.zc_s1 = zero_cross;
    nxt_r.zc_s2 = r_ff.zc_s1;
    nxt_r.rdata = '0;

    // Writes: config lands in shadow, commit swaps it in as one block
    if (bus.wr) begin
      if (bus.addr == kms_pkg::A_CTRL) begin
        nxt_r.run = bus.wdata[kms_pkg::CTRL_RUN];
        if (bus.wdata[kms_pkg::CTRL_COMMIT]) begin
          if (count_on(r_ff.lim_sh) <= LIMIT5) begin // RULE_02
            nxt_r.lim = r_ff.lim_sh;
            nxt_r.cnt = r_ff.cnt_sh;
            nxt_r.err = 1'b0;
          end else begin
            nxt_r.err = 1'b1; // RULE_02
          end
        end
      end else if (in_win(bus.addr, kms_pkg::A_CFG)) begin
        nxt_r.lim_sh[bus.addr[4:0]] = bus.wdata[7:0];
        nxt_r.cnt_sh[bus.addr[4:0]] = bus.wdata[15:8];
      end
    end

    // Reads answer one cycle later; unmapped reads return zero
    if (bus.rd) begin
      if (bus.addr == kms_pkg::A_CTRL) begin
        nxt_r.rdata = {29'h0, r_ff.err, 1'b0, r_ff.run};
      end else if (bus.addr == kms_pkg::A_STATUS) begin
        nxt_r.rdata = {r_ff.scans, 3'h0, r_ff.key, 7'h0, r_ff.st != kms_pkg::ST_IDLE};
      end else if (in_win(bus.addr, kms_pkg::A_CFG)) begin
        nxt_r.rdata = {16'h0, r_ff.cnt_sh[bus.addr[4:0]], r_ff.lim_sh[bus.addr[4:0]]};
      end else if (in_win(bus.addr, kms_pkg::A_MEAS)) begin
        nxt_r.rdata = {16'h0, r_ff.meas[bus.addr[4:0]]};
      end
    end

    // Sequencer: one key at a time, burst then conversion
    case (r_ff.st)
      kms_pkg::ST_IDLE: begin
        if (r_ff.run) begin
          nxt_r.st = kms_pkg::ST_SELECT;
          nxt_r.key = 5'h00; // RULE_06
        end
      end
      kms_pkg::ST_SELECT: begin
        // Disabled key costs two cycles (select, then next), never a timeslot
        if (key_on(r_ff.lim, r_ff.key)) begin // RULE_03
          nxt_r.st = kms_pkg::ST_HI;
          nxt_r.pulses = r_ff.cnt[r_ff.key]; // RULE_08
          nxt_r.tmr = DWELL_LD;
          nxt_r.drive = drv_sel(r_ff.key); // RULE_01
        end else begin
          nxt_r.st = kms_pkg::ST_NEXT;
        end
      end
      kms_pkg::ST_HI: begin
        // Capture window length is a constant, not a register
        if (r_ff.tmr == 8'h00) begin // RULE_12
          nxt_r.drive = '0;
          nxt_r.clamp = rcv_sel(r_ff.key); // RULE_10
          nxt_r.tmr = LOW_LD;
          nxt_r.st = kms_pkg::ST_LO;
        end else begin
          nxt_r.tmr = r_ff.tmr - 8'h01;
        end
      end
      kms_pkg::ST_LO: begin
        if (r_ff.tmr != 8'h00) begin
          nxt_r.tmr = r_ff.tmr - 8'h01;
        end else if (r_ff.pulses <= 8'h01) begin
          // Clamp stays on into the conversion
          nxt_r.st = kms_pkg::ST_CLAMP; // RULE_09
          nxt_r.tmr = CLAMP_LD;
        end else begin
          nxt_r.pulses = r_ff.pulses - 8'h01; // RULE_08
          nxt_r.clamp = '0; // RULE_10
          nxt_r.drive = drv_sel(r_ff.key);
          nxt_r.tmr = DWELL_LD;
          nxt_r.st = kms_pkg::ST_HI;
        end
      end
      kms_pkg::ST_CLAMP: begin
        if (r_ff.tmr == 8'h00) begin
          nxt_r.clamp = '0; // RULE_11
          nxt_r.conv = 16'h0000;
          nxt_r.st = kms_pkg::ST_RAMP;
        end else begin
          nxt_r.tmr = r_ff.tmr - 8'h01;
        end
      end
      kms_pkg::ST_RAMP: begin
        // Stuck comparator would hang the scan, so the count saturates
        if (zc_now) begin
          nxt_r.meas[r_ff.key] = r_ff.conv; // RULE_11
          nxt_r.st = kms_pkg::ST_NEXT;
        end else if (r_ff.conv == kms_pkg::CONV_MAX) begin
          nxt_r.meas[r_ff.key] = kms_pkg::CONV_MAX; // RULE_14
          nxt_r.st = kms_pkg::ST_NEXT;
        end else begin
          nxt_r.conv = r_ff.conv + 16'h0001;
        end
      end
      kms_pkg::ST_NEXT: begin
        // Drive index is the low key bits, so it steps fastest
        if (r_ff.key == kms_pkg::LAST_KEY) begin // RULE_06
          nxt_r.key = 5'h00;
          nxt_r.scans = r_ff.scans + 16'h0001;
          nxt_r.st = r_ff.run ? kms_pkg::ST_SELECT : kms_pkg::ST_IDLE;
        end else begin
          nxt_r.key = r_ff.key + 5'h01;
          nxt_r.st = kms_pkg::ST_SELECT;
        end
      end
      default: begin
        nxt_r.st = kms_pkg::ST_IDLE;
      end
    endcase

    if (srst) begin
      nxt_r = rst_val();
    end
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------

  // Whole block state in one register
  always_ff @(posedge clock) begin
    r_ff <= nxt_r;
  end

  assign bus_rdata = r_ff.rdata;
  assign pins = '{drive: r_ff.drive, clamp: r_ff.clamp}; // One driver for the pin struct

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  logic [7:0] hi_len_ff;
  logic [7:0] rises_ff;
  logic committed_ff;
  logic [7:0] want_ff; // Latched at select, so a mid-scan load cannot upset it

  // Helper counters seen only by the checks
  always_ff @(posedge clock) begin
    if (srst) begin
      hi_len_ff <= 8'h00;
      rises_ff <= 8'h00;
      committed_ff <= 1'b0;
      want_ff <= 8'h00;
    end else begin
      hi_len_ff <= (|r_ff.drive) ? hi_len_ff + 8'h01 : 8'h00;
      if (r_ff.st == kms_pkg::ST_SELECT) begin
        rises_ff <= 8'h00;
        want_ff <= r_ff.cnt[r_ff.key];
      end else if (r_ff.st == kms_pkg::ST_HI && r_ff.tmr == DWELL_LD) begin
        rises_ff <= rises_ff + 8'h01;
      end
      if (bus.wr && bus.addr == kms_pkg::A_CTRL && bus.wdata[kms_pkg::CTRL_COMMIT]) begin
        committed_ff <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_dwell_fixed: assert property ( // RULE_12
    $fell(|pins.drive) |-> hi_len_ff == 8'(kms_pkg::DWELL_CYC))
    else $error("drive high time differs from capture window");

  a_clamp_on_fall: assert property ( // RULE_10
    $fell(|pins.drive) && r_ff.st == kms_pkg::ST_LO
      |-> pins.clamp == rcv_sel(r_ff.key) ##1 $stable(pins.clamp))
    else $error("receive not clamped after drive fall");

  a_no_overlap: assert property ( // RULE_09
    (|pins.drive) |-> r_ff.st == kms_pkg::ST_HI && pins.clamp == '0)
    else $error("drive active outside a burst pulse");

  a_skip_disabled: assert property ( // RULE_03
    r_ff.st == kms_pkg::ST_SELECT && !key_on(r_ff.lim, r_ff.key)
      |=> r_ff.st == kms_pkg::ST_NEXT && pins.drive == '0)
    else $error("disabled key was scanned");

  a_key_order: assert property ( // RULE_06
    r_ff.st == kms_pkg::ST_NEXT && r_ff.key != kms_pkg::LAST_KEY
      |=> r_ff.key == $past(r_ff.key) + 5'h01)
    else $error("key sequence skipped an index");

  a_key_map: assert property ( // RULE_07
    $rose(|pins.drive) |-> pins.drive == drv_sel(r_ff.key) && r_ff.key <= kms_pkg::LAST_KEY)
    else $error("drive line does not match key number");

  a_limit_held: assert property ( // RULE_02
    count_on(r_ff.lim) <= LIMIT5)
    else $error("enabled keys exceed variant limit");

  a_reset_enable: assert property ( // RULE_05
    !committed_ff && KEY_LIMIT == 16 |-> r_ff.lim[23:16] == '0)
    else $error("third receive line enabled at reset");

  a_burst_len: assert property ( // RULE_08
    $rose(r_ff.st == kms_pkg::ST_CLAMP)
      |-> rises_ff == ((want_ff == 8'h00) ? 8'h01 : want_ff))
    else $error("burst pulse count differs from key setting");

  a_ramp_start: assert property ( // RULE_11
    $rose(r_ff.st == kms_pkg::ST_RAMP) |-> pins.clamp == '0 && r_ff.conv == 16'h0000)
    else $error("conversion started with clamp active");

  a_conv_sat: assert property ( // RULE_14
    r_ff.st == kms_pkg::ST_RAMP && r_ff.conv == kms_pkg::CONV_MAX && !zc_now
      |=> r_ff.meas[r_ff.key] == kms_pkg::CONV_MAX && r_ff.st == kms_pkg::ST_NEXT)
    else $error("conversion did not saturate");

  // ----------------------------------------------------------------
  // Sequencing and register port checks
  // ----------------------------------------------------------------

  a_clamp_hold: assert property ( // RULE_11
    $rose(r_ff.st == kms_pkg::ST_CLAMP) |-> pins.clamp == rcv_sel(r_ff.key))
    else $error("receive line not clamped after burst");

  a_ramp_step: assert property ( // RULE_11
    r_ff.st == kms_pkg::ST_RAMP && !zc_now && r_ff.conv != kms_pkg::CONV_MAX
      |=> r_ff.st == kms_pkg::ST_RAMP && r_ff.conv == $past(r_ff.conv) + 16'h0001)
    else $error("conversion counter missed a step");

  a_meas_store: assert property ( // RULE_11
    r_ff.st == kms_pkg::ST_RAMP && zc_now
      |=> r_ff.st == kms_pkg::ST_NEXT && r_ff.meas[r_ff.key] == $past(r_ff.conv))
    else $error("crossing count not stored for key");

  a_commit_refused: assert property ( // RULE_02
    bus.wr && bus.addr == kms_pkg::A_CTRL && bus.wdata[kms_pkg::CTRL_COMMIT]
      && count_on(r_ff.lim_sh) > LIMIT5 |=> r_ff.err && r_ff.lim == $past(r_ff.lim))
    else $error("oversized block load changed active keys");

  a_lines_onehot: assert property ( // RULE_01
    $onehot0(pins.drive) && $onehot0(pins.clamp))
    else $error("more than one drive or receive line active");

  a_idle_quiet: assert property ( // RULE_09
    r_ff.st == kms_pkg::ST_IDLE || r_ff.st == kms_pkg::ST_SELECT
      |-> pins.drive == '0 && pins.clamp == '0)
    else $error("lines active between keys");

  a_rdata_idle: assert property (
    !$past(bus.rd) |-> bus_rdata == '0)
    else $error("read data present without a read");

  c_scan_wrap: cover property (r_ff.st == kms_pkg::ST_NEXT && r_ff.key == kms_pkg::LAST_KEY);
  c_saturate: cover property (r_ff.st == kms_pkg::ST_RAMP && r_ff.conv == kms_pkg::CONV_MAX);
  c_commit_bad: cover property ($rose(r_ff.err));
  c_zero_cross: cover property (r_ff.st == kms_pkg::ST_RAMP && zc_now);
  c_multi_pulse: cover property ($rose(r_ff.st == kms_pkg::ST_CLAMP) && rises_ff > 8'h01);

endmodule : kms_scan

// File: bench/kms_matrix_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Electrode matrix with sample capacitor, ramp resistor, comparator
// ----------------------------------------------------------------
module kms_matrix_model (
  input wire logic clock,
  input wire logic srst,
  input wire kms_pkg::kms_pins_t pins,
  input wire logic [15:0] delay,
  input wire logic no_cross,
  output logic [kms_pkg::N_RCV-1:0] zero_cross
);
  logic [kms_pkg::N_RCV-1:0][15:0] ramp_ff;

  // Ramp restarts while the line is clamped or any drive pulses
  always_ff @(posedge clock) begin
    for (int r = 0; r < kms_pkg::N_RCV; r++) begin
      if (srst || pins.clamp[r] || pins.drive != 8'h00) begin
        ramp_ff[r] <= 16'h0000;
      end else if (ramp_ff[r] != 16'hFFFF) begin
        ramp_ff[r] <= ramp_ff[r] + 16'h0001;
      end
    end
  end

  // Crossing after a fixed ramp time; no_cross models a stuck comparator
  always_comb begin
    for (int r = 0; r < kms_pkg::N_RCV; r++) begin
      zero_cross[r] = !no_cross && (ramp_ff[r] >= delay);
    end
  end
endmodule : kms_matrix_model

// File: bench/tb_key_matrix_scan_sequencer.sv
`timescale 1ns/1ps
module tb_key_matrix_scan_sequencer;
  logic clock = 1'b0;
  logic srst = 1'b1;
  kms_pkg::kms_bus_t bus = '0;
  logic [31:0] bus_rdata;
  kms_pkg::kms_pins_t pins;
  logic [kms_pkg::N_RCV-1:0] zero_cross;
  logic [15:0] delay = 16'h0028;
  logic no_cross = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] log_q[$];
  int wid_q[$];
  int hcnt = 0;
  logic [7:0] prev_drv = 8'h00;

  // ----------------------------------------------------------------
  // Clock, design, far side
  // ----------------------------------------------------------------
  always #2.5 clock = ~clock;

  // Short low and clamp phases keep the run brief
  kms_scan #(.KEY_LIMIT(16), .LOW_CYC(2), .CLAMP_CYC(2)) kms_scan_inst (
    .clock(clock), .srst(srst), .bus(bus), .bus_rdata(bus_rdata),
    .pins(pins), .zero_cross(zero_cross));

  kms_matrix_model kms_matrix_model_inst (
    .clock(clock), .srst(srst), .pins(pins), .delay(delay),
    .no_cross(no_cross), .zero_cross(zero_cross));

  // ----------------------------------------------------------------
  // Pin monitor: logs receive line and drive index at each falling edge
  // ----------------------------------------------------------------
  always @(posedge clock) begin : mon
    logic [2:0] ix;
    ix = 3'h0;
    for (int b = 0; b < 8; b++) if (prev_drv[b]) ix = 3'(b);
    if (pins.drive != 8'h00) hcnt++;
    if (pins.drive != 8'h00 && pins.clamp != 3'h0) begin
      err_count++;
      $display("CHECK FAILED clamp expected 0 seen %0h", pins.clamp);
    end
    if (prev_drv != 8'h00 && pins.drive == 8'h00) begin
      log_q.push_back({pins.clamp, 2'b00, ix});
      wid_q.push_back(hcnt);
      hcnt = 0;
    end
    prev_drv = pins.drive;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd

  // Enable set per key; pulse count k mod 5, so key 0 asks for zero pulses
  task automatic cfg_all(logic [23:0] en);
    for (int k = 0; k < 24; k++) begin
      wr(kms_pkg::A_CFG + 8'(k), {16'h0000, 8'(k % 5), en[k] ? 8'h03 : 8'h00});
    end
    wr(kms_pkg::A_CTRL, 32'h0000_0002);
  endtask : cfg_all

  // One pass: run pulses high, then low; the pass ends after key 23
  task automatic scan_once(int lim);
    logic [31:0] s0;
    logic [31:0] d;
    int n;
    rd(kms_pkg::A_STATUS, s0);
    wr(kms_pkg::A_CTRL, 32'h0000_0001);
    wr(kms_pkg::A_CTRL, 32'h0000_0000);
    n = 0;
    do begin
      rd(kms_pkg::A_STATUS, d);
      n++;
    end while (d[0] !== 1'b0 && n < lim);
    check("scan idle", 32'h0, {31'h0, d[0]});
    check("scan count", {16'h0000, s0[31:16] + 16'h0001}, {16'h0000, d[31:16]});
  endtask : scan_once

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [7:0] lim;
    for (int k = 0; k < 24; k++) begin
      rd(kms_pkg::A_CFG + 8'(k), d);
      lim = (k < 16) ? kms_pkg::RST_LIMIT : 8'h00; // Pulse count resets on every key
      check("reset cfg", {16'h0, kms_pkg::RST_PULSES, lim}, d);
    end
    rd(8'h10, d);
    check("unmapped read", 32'h0, d);
    rd(kms_pkg::A_CTRL, d);
    check("reset ctrl", 32'h0, d);
  endtask : t_reset

  // Seventeen keys in one load must be refused on the small variant
  task automatic t_limit();
    logic [31:0] d;
    cfg_all(24'h01_FFFF);
    rd(kms_pkg::A_CTRL, d);
    check("ctrl err", 32'h1, {31'h0, d[kms_pkg::CTRL_ERR]});
  endtask : t_limit

  // Keys 0, 9 and 23 only; one load also drops the reset keys
  task automatic t_order();
    logic [7:0] exp[$];
    cfg_all(24'h80_0201);
    log_q.delete();
    wid_q.delete();
    scan_once(2000);
    exp = {8'h20, 8'h41, 8'h41, 8'h41, 8'h41, 8'h87, 8'h87, 8'h87};
    check("pulse total", 32'(exp.size()), 32'(log_q.size()));
    for (int i = 0; i < exp.size() && i < log_q.size(); i++) begin
      check("pulse key", {24'h0, exp[i]}, {24'h0, log_q[i]});
      check("dwell", 32'(kms_pkg::DWELL_CYC), 32'(wid_q[i]));
    end
  endtask : t_order

  // Twenty more ramp cycles add twenty counts, a swing above the 12-count target
  task automatic t_meas();
    logic [31:0] m1;
    logic [31:0] m2;
    cfg_all(24'h00_0001);
    @(posedge clock) delay <= 16'h0028;
    scan_once(2000);
    rd(kms_pkg::A_MEAS, m1);
    @(posedge clock) delay <= 16'h003C;
    scan_once(2000);
    rd(kms_pkg::A_MEAS, m2);
    check("ramp delta", 32'h14, m2 - m1);
  endtask : t_meas

  task automatic t_sat();
    logic [31:0] m;
    @(posedge clock) no_cross <= 1'b1;
    scan_once(40000);
    rd(kms_pkg::A_MEAS, m);
    check("saturated", 32'h0000_FFFF, m);
  endtask : t_sat

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_limit();
    t_order();
    t_meas();
    t_sat();
    final_report();
  end

  // Saturation pass dominates: about 66k cycles expected in total
  initial begin
    repeat (95000) @(posedge clock);
    err_count++;
    final_report();
  end
endmodule : tb_key_matrix_scan_sequencer
